// file: bench/atd_regs_sva.sv
// Checker for the trim and dither register bank.
`timescale 1ns/1ns
`default_nettype none
module atd_regs_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire atd_pkg::atd_req_t req, // Bus request
  input wire logic [atd_pkg::ATD_DW-1:0] rdata, // Read data
  input wire atd_pkg::atd_fuse_t fuse, // Fuse image
  input wire logic fuse_valid, // Fuse settled
  input wire atd_pkg::atd_trim_t trim, // Front end settings
  input wire logic load_done // Preload finished
);
  import atd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Only writes once load_done is up count; a write in the one cycle before it already lands but goes unchecked.
  wire logic w = req.wr && load_done;
  wire logic [9:0] a = req.addr;
  wire logic [7:0] d = req.wdata;
  wire logic [2:0] dq = {trim.rounding_error_placement, trim.dither_amplitude_select,
    trim.dither_enable};
  // Trim lags the register by one cycle, so each check looks two edges on.
  property p_ga; w && a == ATD_OFS_GAIN_A |-> ##2 trim.gain_a == $past(d, 2); endproperty
  a_ga: assert property (p_ga) else $error("gain a trim wrong");
  property p_gb; w && a == ATD_OFS_GAIN_B |-> ##2 trim.gain_b == $past(d, 2); endproperty
  a_gb: assert property (p_gb) else $error("gain b trim wrong");
  property p_rf; w && a == ATD_OFS_REF |-> ##2 trim.ref_adj == $past(d[3:0], 2); endproperty
  a_rf: assert property (p_rf) else $error("reference trim wrong");
  property p_ta; w && a == ATD_OFS_TERM_A |-> ##2 trim.term_a == $past(d, 2); endproperty
  a_ta: assert property (p_ta) else $error("termination a wrong");
  property p_tb; w && a == ATD_OFS_TERM_B |-> ##2 trim.term_b == $past(d, 2); endproperty
  a_tb: assert property (p_tb) else $error("termination b wrong");
  property p_de; w && a == ATD_OFS_DITHER |-> ##2 dq[0] == $past(d[0], 2); endproperty
  a_de: assert property (p_de) else $error("dither enable wrong");
  property p_da; w && a == ATD_OFS_DITHER |-> ##2 dq[1] == $past(d[1], 2); endproperty
  a_da: assert property (p_da) else $error("dither amplitude wrong");
  property p_dr; w && a == ATD_OFS_DITHER |-> ##2 dq[2] == $past(d[2], 2); endproperty
  a_dr: assert property (p_dr) else $error("rounding placement wrong");
  c_ld: cover property ($rose(load_done));
  c_rd: cover property (req.rd && a == ATD_OFS_REF);
  c_dw: cover property (w && a == ATD_OFS_DITHER);
endmodule
bind atd_regs atd_regs_sva u_sva (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
  .fuse(fuse), .fuse_valid(fuse_valid), .trim(trim), .load_done(load_done));
`default_nettype wire

// file: bench/tb_atd_regs.sv
// Self-checking bench for the trim and dither register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_atd_regs;
  import atd_pkg::*;
  logic clk, rst_n, fuse_valid, load_done;
  logic [7:0] rdata;
  atd_req_t req;
  atd_fuse_t fuse;
  atd_trim_t trim;
  int n_errors, checks;
  localparam logic [9:0] OFS [6] = '{ATD_OFS_GAIN_A, ATD_OFS_GAIN_B, ATD_OFS_REF,
    ATD_OFS_TERM_A, ATD_OFS_TERM_B, ATD_OFS_DITHER};
  localparam logic [7:0] MSK [6] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h07};
  atd_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .fuse(fuse),
    .fuse_valid(fuse_valid), .trim(trim), .load_done(load_done));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [38:0] e, input logic [38:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand for one cycle only, so they are taken just after that edge.
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_preload;
    logic [7:0] d;
    logic [7:0] ex [6];
    ex = '{fuse.gain_a, fuse.gain_b, {4'h0, fuse.ref_adj}, fuse.term_a, fuse.term_b, 8'h01};
    for (int i = 0; i < 6; i++) begin
      rd(OFS[i], d);
      chk("preload read", 39'(ex[i]), 39'(d));
    end
    chk("preload trim", {fuse, 3'b100}, trim);
  endtask
  task automatic t_rw;
    logic [7:0] d;
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'hff : 8'h00;
      // All six registers at their field masks, then the unmapped offset 07d.
      for (int i = 0; i < 6; i++) wr(OFS[i], v & MSK[i]);
      wr(10'h07d, v);
      for (int i = 0; i < 6; i++) begin
        rd(OFS[i], d);
        chk("read back", 39'(v & MSK[i]), 39'(d));
      end
      rd(10'h07d, d);
      chk("unmapped read", 39'h0, 39'(d));
      chk("trim after write", {39{v[0]}}, trim);
    end
  endtask
  task automatic t_dither;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      wr(ATD_OFS_DITHER, 8'(i));
      rd(ATD_OFS_DITHER, d);
      chk("dither read", 39'(i), 39'(d));
      chk("dither trim", 39'({i[0], i[1], i[2]}), 39'(trim[2:0]));
    end
  endtask
  // A second reset with fuse storage not yet settled: the bank waits, keeps
  // its reset values and drops early writes, then loads the new fuse word.
  task automatic t_reload;
    logic [7:0] d;
    @(posedge clk);
    rst_n <= 1'b0;
    fuse_valid <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ATD_OFS_GAIN_A, 8'h11);
    rd(ATD_OFS_GAIN_A, d);
    chk("early write", 39'(ATD_RST_TRIM), 39'(d));
    rd(ATD_OFS_DITHER, d);
    chk("dither reset", 39'(ATD_RST_DITHER), 39'(d));
    chk("load waits", 39'h0, 39'(load_done));
    @(posedge clk);
    fuse <= '{8'h81, 8'h7e, 4'h6, 8'h24, 8'hdb};
    fuse_valid <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("load again", 39'h1, 39'(load_done));
    t_preload;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    stop_test;
  end
  initial begin
    rst_n = 1'b0;
    fuse_valid = 1'b1;
    req = '0;
    fuse = '{8'h3c, 8'hc3, 4'h9, 8'h5a, 8'ha6};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Writes are dropped until the preload ends, so wait for it first.
    for (int i = 0; i < 20 && load_done !== 1'b1; i++) @(posedge clk);
    chk("load done", 39'h1, 39'(load_done));
    t_preload;
    t_rw;
    t_dither;
    t_reload;
    stop_test;
  end
endmodule
`default_nettype wire

// file: logic/atd_pkg.sv
// Package for the analog trim and dither register bank: offsets, resets and carriers.
`default_nettype none
package atd_pkg;

  localparam int ATD_AW = 10;
  localparam int ATD_DW = 8;

  // Register offsets.
  localparam logic [ATD_AW-1:0] ATD_OFS_GAIN_A = 10'h07a;
  localparam logic [ATD_AW-1:0] ATD_OFS_GAIN_B = 10'h07b;
  localparam logic [ATD_AW-1:0] ATD_OFS_REF = 10'h07c;
  localparam logic [ATD_AW-1:0] ATD_OFS_TERM_A = 10'h07e;
  localparam logic [ATD_AW-1:0] ATD_OFS_TERM_B = 10'h07f;
  localparam logic [ATD_AW-1:0] ATD_OFS_DITHER = 10'h09d;

  // Field layout.
  localparam int ATD_REF_MSB = 3;
  localparam int ATD_DITH_EN_BIT = 0;
  localparam int ATD_DITH_AMP_BIT = 1;
  localparam int ATD_DITH_ERR_BIT = 2;
  localparam logic [7:0] ATD_REF_MASK = 8'h0f;
  localparam logic [7:0] ATD_DITH_MASK = 8'h07;

  // Values after reset, before the fuse load overwrites the trims.
  localparam logic [7:0] ATD_RST_TRIM = 8'h00;
  localparam logic [7:0] ATD_RST_DITHER = 8'h01;

  // Register bus request.
  typedef struct packed {
    logic [ATD_AW-1:0] addr;
    logic [ATD_DW-1:0] wdata;
    logic wr;
    logic rd;
  } atd_req_t;

  // Factory fuse image for the five trim registers.
  typedef struct packed {
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [3:0] ref_adj;
    logic [7:0] term_a;
    logic [7:0] term_b;
  } atd_fuse_t;

  // Settings that steer the analog front end.
  typedef struct packed {
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [3:0] ref_adj;
    logic [7:0] term_a;
    logic [7:0] term_b;
    logic dither_enable;
    logic dither_amplitude_select;
    logic rounding_error_placement;
  } atd_trim_t;

  typedef enum logic [2:0] {
    ATD_ST_RESET = 3'b001,
    ATD_ST_LOAD = 3'b010,
    ATD_ST_RUN = 3'b100
  } atd_state_t;

endpackage
`default_nettype wire

// file: logic/atd_regs.sv
// Analog trim and dither register bank with fuse preload after reset.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Channel A gain adjust, fuse preloaded, RW
// - Channel B gain adjust, fuse preloaded, RW
// - Four-bit reference adjust, upper nibble reserved
// - Channel A termination adjust, fuse preloaded, RW
// - Channel B termination adjust, fuse preloaded, RW
// - Dither enable bit zero, resets set
// - Bit one selects large dither amplitude
// - Bit two selects rounding error placement
module atd_regs (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire atd_pkg::atd_req_t req, // Address, write data and strobes
  output logic [atd_pkg::ATD_DW-1:0] rdata, // Read data, cycle after read strobe
  input wire atd_pkg::atd_fuse_t fuse, // Factory trim from fuse storage
  input wire logic fuse_valid, // Fuse storage has settled, from pins
  output atd_pkg::atd_trim_t trim, // Settings to the analog front end
  output logic load_done // Fuse preload has completed
);
  import atd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Fuse handshake synchroniser; fuse storage lives outside this clock.

  logic fv_meta_reg;
  logic fv_sync_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fv_meta_reg <= 1'b0;
      fv_sync_reg <= 1'b0;
    end else begin
      fv_meta_reg <= fuse_valid;
      fv_sync_reg <= fv_meta_reg;
    end
  end

  // The fuse word crosses through two stages of its own, in step with the
  // valid level, so the word taken at load time has settled like its flag.
  // Two rows of flops are the price; no fuse bit is read while metastable.

  atd_fuse_t fuse_meta_reg;
  atd_fuse_t fuse_sync_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuse_meta_reg <= '0;
      fuse_sync_reg <= '0;
    end else begin
      fuse_meta_reg <= fuse;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // Fuse fields by name, as the registers take them at load time. Only the
  // second stage is read, never the first.
  wire [7:0] fuse_gain_a = fuse_sync_reg.gain_a;
  wire [7:0] fuse_gain_b = fuse_sync_reg.gain_b;
  wire [3:0] fuse_ref = fuse_sync_reg.ref_adj;
  wire [7:0] fuse_term_a = fuse_sync_reg.term_a;
  wire [7:0] fuse_term_b = fuse_sync_reg.term_b;

  //////////////////////////////////////////////////////////////////////////////
  // Load sequencer. RESET lasts one cycle so that the synchroniser has
  // cleared before LOAD looks at it. Only a reset brings the sequencer
  // back, so the fuse word is taken once per reset; a valid level that
  // drops later changes nothing.

  atd_state_t state_reg;
  atd_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ATD_ST_RESET: begin
        state_next = ATD_ST_LOAD;
      end
      ATD_ST_LOAD: begin
        if (fv_sync_reg) begin
          state_next = ATD_ST_RUN;
        end
      end
      ATD_ST_RUN: begin
        state_next = ATD_ST_RUN;
      end
      default: begin
        state_next = ATD_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ATD_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  wire fuse_take = (state_reg == ATD_ST_LOAD) && fv_sync_reg;
  wire running = (state_reg == ATD_ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode. Writes before the preload ends are dropped, so the fuse
  // value never loses to an early write it would then silently overwrite.

  wire wr_ok = req.wr && running;
  // A full ten-bit compare keeps aliases above the map unmapped.
  wire hit_gain_a = (req.addr == ATD_OFS_GAIN_A);
  wire hit_gain_b = (req.addr == ATD_OFS_GAIN_B);
  wire hit_ref = (req.addr == ATD_OFS_REF);
  wire hit_term_a = (req.addr == ATD_OFS_TERM_A);
  wire hit_term_b = (req.addr == ATD_OFS_TERM_B);
  wire hit_dither = (req.addr == ATD_OFS_DITHER);

  // One write enable per register. A write before the preload ends is
  // dropped rather than held, since holding it would need a buffer.
  wire we_gain_a = wr_ok && hit_gain_a;
  wire we_gain_b = wr_ok && hit_gain_b;
  wire we_ref = wr_ok && hit_ref;
  wire we_term_a = wr_ok && hit_term_a;
  wire we_term_b = wr_ok && hit_term_b;
  wire we_dither = wr_ok && hit_dither;

  // Field slices of the write word for the registers narrower than a byte.
  wire [3:0] wdata_ref = req.wdata[ATD_REF_MSB:0];
  wire [2:0] wdata_dither = req.wdata[ATD_DITH_ERR_BIT:0];

  //////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0] gain_a_reg;
  logic [7:0] gain_b_reg;
  logic [3:0] ref_reg;
  logic [7:0] term_a_reg;
  logic [7:0] term_b_reg;
  logic [2:0] dither_reg;

  // A fuse load and a software write never meet in one cycle: writes are
  // gated off until the sequencer runs, and the load happens just before.

  wire [7:0] gain_a_next =
    fuse_take ? fuse_gain_a :
    we_gain_a ? req.wdata :
    gain_a_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_a_reg <= ATD_RST_TRIM;
    end else begin
      gain_a_reg <= gain_a_next;
    end
  end

  wire [7:0] gain_b_next =
    fuse_take ? fuse_gain_b :
    we_gain_b ? req.wdata :
    gain_b_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_b_reg <= ATD_RST_TRIM;
    end else begin
      gain_b_reg <= gain_b_next;
    end
  end

  wire [3:0] ref_next =
    fuse_take ? fuse_ref :
    we_ref ? wdata_ref :
    ref_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_reg <= ATD_RST_TRIM[ATD_REF_MSB:0];
    end else begin
      ref_reg <= ref_next;
    end
  end

  wire [7:0] term_a_next =
    fuse_take ? fuse_term_a :
    we_term_a ? req.wdata :
    term_a_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_a_reg <= ATD_RST_TRIM;
    end else begin
      term_a_reg <= term_a_next;
    end
  end

  wire [7:0] term_b_next =
    fuse_take ? fuse_term_b :
    we_term_b ? req.wdata :
    term_b_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_b_reg <= ATD_RST_TRIM;
    end else begin
      term_b_reg <= term_b_next;
    end
  end

  // Dither bits; reserved bits are not stored.
  // The dither word is not in the fuse image and keeps its fixed reset.
  wire [2:0] dither_next =
    we_dither ? wdata_dither :
    dither_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dither_reg <= ATD_RST_DITHER[2:0];
    end else begin
      dither_reg <= dither_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path. Reserved bits and unmapped addresses read as zero.

  // Reserved bits are not stored, so they read as zero; software must not
  // lean on that, as the bits carry no meaning.
  wire [7:0] ref_rd = {4'h0, ref_reg};
  wire [7:0] dither_rd = {5'h00, dither_reg};
  // The hits are exclusive, so a flat AND-OR replaces a priority chain.
  wire [7:0] sel_gain_a = hit_gain_a ? gain_a_reg : 8'h00;
  wire [7:0] sel_gain_b = hit_gain_b ? gain_b_reg : 8'h00;
  wire [7:0] sel_ref = hit_ref ? ref_rd : 8'h00;
  wire [7:0] sel_term_a = hit_term_a ? term_a_reg : 8'h00;
  wire [7:0] sel_term_b = hit_term_b ? term_b_reg : 8'h00;
  wire [7:0] sel_dither = hit_dither ? dither_rd : 8'h00;
  wire [7:0] rd_mux =
    sel_gain_a | sel_gain_b | sel_ref |
    sel_term_a | sel_term_b | sel_dither;

  // Data stands only in the cycle after the strobe, zero otherwise, so a
  // stale value never looks like a fresh answer.
  wire [7:0] rdata_next = req.rd ? rd_mux : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Front-end outputs, registered once more so every output is a flop.

  // Dither fields by position, as the front end sees them.
  wire dith_en_q = dither_reg[ATD_DITH_EN_BIT];
  wire dith_amp_q = dither_reg[ATD_DITH_AMP_BIT];
  wire dith_err_q = dither_reg[ATD_DITH_ERR_BIT];

  // The extra stage delays every setting by one cycle after a write. The
  // analog side settles far slower than that, so the lag costs nothing,
  // and the front end never sees a decode glitch.
  wire atd_trim_t trim_next = '{
    gain_a: gain_a_reg,
    gain_b: gain_b_reg,
    ref_adj: ref_reg,
    term_a: term_a_reg,
    term_b: term_b_reg,
    dither_enable: dith_en_q,
    dither_amplitude_select: dith_amp_q,
    rounding_error_placement: dith_err_q
  };

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim <= '0;
    end else begin
      trim <= trim_next;
    end
  end

  // Preload status follows the sequencer by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_done <= 1'b0;
    end else begin
      load_done <= running;
    end
  end

endmodule
`default_nettype wire
